/* File: rtl/pmcr_pkg.sv */
// Constants for the packet modem control register block
package pmcr_pkg;
  // Register select codes on the two address pins
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_CMD = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam logic [1:0] ADDR_MODE = 2'h3;
  // Fields of modem_control
  localparam int CTL_DIV_HI = 7;
  localparam int CTL_DIV_LO = 6;
  localparam int CTL_ALT_CRC = 4;
  localparam int CTL_ALT_FILT = 3;
  localparam int CTL_BINARY = 2;
  localparam int CTL_TOL = 1;
  localparam int CTL_FREEZE = 0;
  // Fields of operating_mode
  localparam int MOD_IRQ_EN = 7;
  localparam int MOD_INV = 6;
  localparam int MOD_DIR = 5;
  localparam int MOD_ZP = 4;
  localparam int MOD_POWER_SAVE = 3;
  localparam int MOD_STATUS_SYMBOL_IRQ_ENABLE = 2;
  localparam int MOD_NEXT_STATUS_SYMBOL_HI = 1;
  localparam int MOD_NEXT_STATUS_SYMBOL_LO = 0;
  // Fields of task_command
  localparam int CMD_AUTONOMOUS_SYNC_DETECT = 7;
  localparam int CMD_EYE = 6;
  localparam int CMD_TASK_HI = 2;
  localparam int CMD_TASK_LO = 0;
  localparam logic [2:0] TASK_NULL = 3'h0;
  localparam logic [2:0] TASK_RESET = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Crystal cycles per symbol in four-level mode
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_CODE0 = 12'h200;
  localparam logic [DIV_W-1:0] DIV_CODE1 = 12'h300;
  localparam logic [DIV_W-1:0] DIV_CODE2 = 12'h400;
  localparam logic [DIV_W-1:0] DIV_CODE3 = 12'h600;
  // Frame sync bit error tolerances
  localparam logic [2:0] TOL_FOUR_LOW = 3'h3;
  localparam logic [2:0] TOL_FOUR_HIGH = 3'h7;
  localparam logic [2:0] TOL_BINARY = 3'h5;
  // Status symbol levels, two's complement
  localparam logic [2:0] LVL_P3 = 3'h3;
  localparam logic [2:0] LVL_P1 = 3'h1;
  localparam logic [2:0] LVL_M1 = 3'h7;
  localparam logic [2:0] LVL_M3 = 3'h5;
  // Host write capture states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_LOW = 2'b01,
    WR_COMMIT = 2'b11
  } pmcr_wr_e;
endpackage : pmcr_pkg

/* File: rtl/pmcr_regs.sv */
// Packet modem control, mode and command registers with symbol divider
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module pmcr_regs (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic HOST_CS_N,
  input wire logic HOST_WR_N,
  input wire logic TASK_ACTIVE,
  input wire logic STATUS_IRQ_FLAG,
  input wire logic STATUS_READ,
  input wire logic SYMBOL_EVENT,
  input wire logic SYMBOL_IS_SPARE,
  input wire logic [1:0] RX_STATUS_CODE,
  output logic DATA_WRITE,
  output logic [7:0] DATA_WDATA,
  output logic SYMBOL_TICK,
  output logic TASK_START,
  output logic [2:0] TASK_CODE,
  output logic TASK_CANCEL,
  output logic BINARY_MODE,
  output logic TRANSMIT_MODE,
  output logic ALT_CHECKSUM,
  output logic ALT_FILTER,
  output logic [2:0] SYNC_TOLERANCE,
  output logic CORRECTION_FREEZE,
  output logic SYMBOL_INVERT,
  output logic ANALOG_ENABLE,
  output logic OSC_ENABLE,
  output logic TX_FILTER_BIAS,
  output logic AUTO_SYNC_ENABLE,
  output logic EYE_ROUTE,
  output logic [2:0] TX_STATUS_LEVEL,
  output logic IRQ_SET,
  output logic STATUS_SYMBOL_READY,
  output logic [1:0] RECEIVED_STATUS_VALUE,
  output logic IRQ_PIN_N_OUT,
  output logic IRQ_PIN_N_OE_N
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] addr_s1, addr_s2;
  logic [7:0] data_s1, data_s2;
  logic cs_n_s1, cs_n_s2, wr_n_s1, wr_n_s2;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      addr_s1 <= 2'h0;
      addr_s2 <= 2'h0;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
    end else begin
      addr_s1 <= HOST_ADDR;
      addr_s2 <= addr_s1;
      data_s1 <= HOST_WDATA;
      data_s2 <= data_s1;
      cs_n_s1 <= HOST_CS_N;
      cs_n_s2 <= cs_n_s1;
      wr_n_s1 <= HOST_WR_N;
      wr_n_s2 <= wr_n_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write capture: data taken at the end of the strobe
  pmcr_pkg::pmcr_wr_e wr_state;
  pmcr_pkg::pmcr_wr_e next_wr_state;
  logic [1:0] wr_addr;
  logic [7:0] wr_data;
  logic commit;

  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      pmcr_pkg::WR_IDLE: begin
        if (!cs_n_s2 && !wr_n_s2) next_wr_state = pmcr_pkg::WR_LOW;
      end
      pmcr_pkg::WR_LOW: begin
        if (wr_n_s2) next_wr_state = pmcr_pkg::WR_COMMIT;
      end
      pmcr_pkg::WR_COMMIT: next_wr_state = pmcr_pkg::WR_IDLE;
      default: next_wr_state = pmcr_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      wr_state <= pmcr_pkg::WR_IDLE;
      wr_addr <= 2'h0;
      wr_data <= 8'h00;
    end else begin
      wr_state <= next_wr_state;
      if (wr_state == pmcr_pkg::WR_LOW && !wr_n_s2) begin
        wr_addr <= addr_s2;
        wr_data <= data_s2;
      end else if (next_wr_state == pmcr_pkg::WR_LOW) begin
        wr_addr <= addr_s2;
        wr_data <= data_s2;
      end
    end
  end

  assign commit = (wr_state == pmcr_pkg::WR_COMMIT);

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] modem_control, operating_mode, task_command;
  logic wr_ctrl, wr_mode, wr_cmd, cmd_ok;

  assign wr_ctrl = commit && wr_addr == pmcr_pkg::ADDR_CTRL;
  assign wr_mode = commit && wr_addr == pmcr_pkg::ADDR_MODE;
  assign wr_cmd = commit && wr_addr == pmcr_pkg::ADDR_CMD;
  assign cmd_ok = wr_cmd && !operating_mode[pmcr_pkg::MOD_ZP];

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      modem_control <= pmcr_pkg::REG_RESET;
      operating_mode <= pmcr_pkg::REG_RESET;
      task_command <= pmcr_pkg::REG_RESET;
    end else begin
      if (wr_ctrl) modem_control <= wr_data;
      if (wr_mode) operating_mode <= wr_data;
      if (cmd_ok) task_command <= wr_data;
    end
  end

  // Data buffer writes pass straight to the buffer logic
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      DATA_WRITE <= 1'b0;
      DATA_WDATA <= 8'h00;
    end else begin
      DATA_WRITE <= commit && wr_addr == pmcr_pkg::ADDR_DATA;
      if (commit) DATA_WDATA <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Task launch and cancel
  logic [2:0] wr_task;
  logic mode_flip, dir_flip;

  assign wr_task = wr_data[pmcr_pkg::CMD_TASK_HI:pmcr_pkg::CMD_TASK_LO];
  assign mode_flip = wr_ctrl && (wr_data[pmcr_pkg::CTL_BINARY]
                     != modem_control[pmcr_pkg::CTL_BINARY]);
  assign dir_flip = wr_mode && (wr_data[pmcr_pkg::MOD_DIR]
                    != operating_mode[pmcr_pkg::MOD_DIR]);

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      TASK_START <= 1'b0;
      TASK_CODE <= pmcr_pkg::TASK_NULL;
      TASK_CANCEL <= 1'b0;
    end else begin
      TASK_START <= cmd_ok && wr_task != pmcr_pkg::TASK_NULL
                    && wr_task != pmcr_pkg::TASK_RESET;
      if (cmd_ok) TASK_CODE <= wr_task;
      TASK_CANCEL <= mode_flip || dir_flip
                     || (cmd_ok && wr_task == pmcr_pkg::TASK_RESET);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Symbol rate divider
  logic [pmcr_pkg::DIV_W:0] ratio;
  logic [pmcr_pkg::DIV_W-1:0] base;
  logic [pmcr_pkg::DIV_W:0] div_cnt;

  always_comb begin
    case (modem_control[pmcr_pkg::CTL_DIV_HI:pmcr_pkg::CTL_DIV_LO])
      2'h0: base = pmcr_pkg::DIV_CODE0;
      2'h1: base = pmcr_pkg::DIV_CODE1;
      2'h2: base = pmcr_pkg::DIV_CODE2;
      default: base = pmcr_pkg::DIV_CODE3;
    endcase
    ratio = modem_control[pmcr_pkg::CTL_BINARY] ? {base, 1'b0} : {1'b0, base};
  end

  // Stopped in zero power; restarts from a full period
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      div_cnt <= '0;
      SYMBOL_TICK <= 1'b0;
    end else if (operating_mode[pmcr_pkg::MOD_ZP] || TASK_CANCEL || div_cnt >= ratio) begin
      div_cnt <= '0;
      SYMBOL_TICK <= 1'b0;
    end else if (div_cnt == ratio - 1'b1) begin
      div_cnt <= '0;
      SYMBOL_TICK <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      SYMBOL_TICK <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls
  logic four_level, rx_mode;

  assign four_level = !modem_control[pmcr_pkg::CTL_BINARY];
  assign rx_mode = !operating_mode[pmcr_pkg::MOD_DIR];
  assign BINARY_MODE = modem_control[pmcr_pkg::CTL_BINARY];
  assign TRANSMIT_MODE = operating_mode[pmcr_pkg::MOD_DIR];
  assign ALT_CHECKSUM = four_level && modem_control[pmcr_pkg::CTL_ALT_CRC];
  assign ALT_FILTER = four_level && modem_control[pmcr_pkg::CTL_ALT_FILT];
  assign SYNC_TOLERANCE = !four_level ? pmcr_pkg::TOL_BINARY :
                          modem_control[pmcr_pkg::CTL_TOL] ? pmcr_pkg::TOL_FOUR_HIGH
                          : pmcr_pkg::TOL_FOUR_LOW;
  assign CORRECTION_FREEZE = modem_control[pmcr_pkg::CTL_FREEZE];
  assign SYMBOL_INVERT = operating_mode[pmcr_pkg::MOD_INV];
  assign ANALOG_ENABLE = !operating_mode[pmcr_pkg::MOD_POWER_SAVE]
                         && !operating_mode[pmcr_pkg::MOD_ZP];
  assign OSC_ENABLE = !operating_mode[pmcr_pkg::MOD_ZP];
  assign TX_FILTER_BIAS = !rx_mode && !TASK_ACTIVE;
  assign AUTO_SYNC_ENABLE = rx_mode && task_command[pmcr_pkg::CMD_AUTONOMOUS_SYNC_DETECT];
  assign EYE_ROUTE = rx_mode && task_command[pmcr_pkg::CMD_EYE];

  // Next status level; receive mode drives none
  always_comb begin
    TX_STATUS_LEVEL = pmcr_pkg::LVL_M1;
    case (operating_mode[pmcr_pkg::MOD_NEXT_STATUS_SYMBOL_HI:pmcr_pkg::MOD_NEXT_STATUS_SYMBOL_LO])
      2'h3: TX_STATUS_LEVEL = four_level ? pmcr_pkg::LVL_P3 : pmcr_pkg::LVL_P1;
      2'h2: TX_STATUS_LEVEL = pmcr_pkg::LVL_P1;
      2'h0: TX_STATUS_LEVEL = pmcr_pkg::LVL_M1;
      default: TX_STATUS_LEVEL = four_level ? pmcr_pkg::LVL_M3 : pmcr_pkg::LVL_M1;
    endcase
    if (rx_mode) TX_STATUS_LEVEL = 3'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status symbol events
  logic sym_hit;

  assign sym_hit = SYMBOL_EVENT && operating_mode[pmcr_pkg::MOD_STATUS_SYMBOL_IRQ_ENABLE]
                   && !(BINARY_MODE && SYMBOL_IS_SPARE);

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      IRQ_SET <= 1'b0;
      STATUS_SYMBOL_READY <= 1'b0;
      RECEIVED_STATUS_VALUE <= 2'h0;
    end else begin
      IRQ_SET <= sym_hit;
      // Set wins over a same-cycle status read
      if (sym_hit) STATUS_SYMBOL_READY <= 1'b1;
      else if (STATUS_READ) STATUS_SYMBOL_READY <= 1'b0;
      if (sym_hit && rx_mode) RECEIVED_STATUS_VALUE <= RX_STATUS_CODE;
    end
  end

  // Open-drain interrupt pin
  assign IRQ_PIN_N_OUT = 1'b0;
  assign IRQ_PIN_N_OE_N = !(operating_mode[pmcr_pkg::MOD_IRQ_EN] && STATUS_IRQ_FLAG);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_zp_blocks;
    @(posedge REF_CLK) disable iff (!RESET_N)
      wr_cmd && operating_mode[pmcr_pkg::MOD_ZP] |=> !TASK_START && $stable(task_command);
  endproperty
  a_zp_blocks: assert property (p_zp_blocks) else $error("command taken in zero power");
  property p_rx_value;
    @(posedge REF_CLK) disable iff (!RESET_N)
      SYMBOL_EVENT && operating_mode[pmcr_pkg::MOD_STATUS_SYMBOL_IRQ_ENABLE] && rx_mode && !SYMBOL_IS_SPARE
      |=> RECEIVED_STATUS_VALUE == $past(RX_STATUS_CODE);
  endproperty
  a_rx_value: assert property (p_rx_value) else $error("status value not stored");
  property p_ready_clear;
    @(posedge REF_CLK) disable iff (!RESET_N)
      STATUS_READ && !sym_hit |=> !STATUS_SYMBOL_READY;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");
  property p_task_start;
    @(posedge REF_CLK) disable iff (!RESET_N)
      cmd_ok && wr_task != pmcr_pkg::TASK_NULL && wr_task != pmcr_pkg::TASK_RESET
      |=> TASK_START && TASK_CODE == $past(wr_task);
  endproperty
  a_task_start: assert property (p_task_start) else $error("task not started");
  property p_dir_cancel;
    @(posedge REF_CLK) disable iff (!RESET_N)
      $changed(operating_mode[pmcr_pkg::MOD_DIR]) |-> TASK_CANCEL;
  endproperty
  a_dir_cancel: assert property (p_dir_cancel) else $error("no cancel on direction");
  property p_mode_cancel;
    @(posedge REF_CLK) disable iff (!RESET_N)
      $changed(BINARY_MODE) |-> TASK_CANCEL;
  endproperty
  a_mode_cancel: assert property (p_mode_cancel) else $error("no cancel on protocol");
  property p_irq_pin;
    @(posedge REF_CLK) disable iff (!RESET_N)
      IRQ_PIN_N_OE_N == !(operating_mode[pmcr_pkg::MOD_IRQ_EN] && STATUS_IRQ_FLAG);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");
  property p_spare;
    @(posedge REF_CLK) disable iff (!RESET_N)
      SYMBOL_EVENT && SYMBOL_IS_SPARE && BINARY_MODE |=> !IRQ_SET;
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit raised interrupt");
  property p_sym_ready;
    @(posedge REF_CLK) disable iff (!RESET_N)
      SYMBOL_EVENT && operating_mode[pmcr_pkg::MOD_STATUS_SYMBOL_IRQ_ENABLE] && !SYMBOL_IS_SPARE
      |=> IRQ_SET && STATUS_SYMBOL_READY;
  endproperty
  a_sym_ready: assert property (p_sym_ready) else $error("symbol flags not set");
  property p_tick_gap;
    @(posedge REF_CLK) disable iff (!RESET_N)
      SYMBOL_TICK && ratio == pmcr_pkg::DIV_CODE0 && $stable(ratio)
      |=> !SYMBOL_TICK [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("symbol tick too fast");
  property p_tol;
    @(posedge REF_CLK) disable iff (!RESET_N)
      BINARY_MODE |-> SYNC_TOLERANCE == pmcr_pkg::TOL_BINARY;
  endproperty
  a_tol: assert property (p_tol) else $error("binary tolerance wrong");
  c_task: cover property (@(posedge REF_CLK) disable iff (!RESET_N) TASK_START);
  c_reset_task: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    cmd_ok && wr_task == pmcr_pkg::TASK_RESET);
  c_symbol: cover property (@(posedge REF_CLK) disable iff (!RESET_N) IRQ_SET && rx_mode);
endmodule : pmcr_regs
`default_nettype wire

/* File: dv/pmcr_host_model.sv */
// Host microcontroller model writing the modem register port
`timescale 1ns/1ns
`default_nettype none
module pmcr_host_model #(
  parameter int STARTUP_CYCLES = 40
) (
  input wire logic ref_clk,
  input wire logic buffer_free_flag,
  output logic [1:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_cs_n,
  output logic host_wr_n
);
  logic osc_wait;
  logic zp_on;
  initial begin
    host_addr = 2'h0;
    host_wdata = 8'h00;
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    osc_wait = 1'b1;
    zp_on = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic write_reg(input logic [1:0] addr, input logic [7:0] data);
    logic [7:0] val;
    val = data;
    if (addr == pmcr_pkg::ADDR_CTRL) begin
      val[5] = 1'b0;
    end
    if (addr == pmcr_pkg::ADDR_CMD) begin
      val[5:3] = 3'h0;
      if (!buffer_free_flag && val[2:0] != pmcr_pkg::TASK_RESET) begin
        val[2:0] = pmcr_pkg::TASK_NULL;
      end
      if (osc_wait && !zp_on) begin
        repeat (STARTUP_CYCLES) @(negedge ref_clk);
        osc_wait = 1'b0;
      end
    end
    if (addr == pmcr_pkg::ADDR_MODE) begin
      osc_wait = osc_wait | (zp_on & ~val[pmcr_pkg::MOD_ZP]);
      zp_on = val[pmcr_pkg::MOD_ZP];
    end
    @(negedge ref_clk);
    host_addr = addr;
    host_wdata = val;
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    host_wr_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    // Released pins no longer show the written byte
    host_cs_n = 1'b1;
    host_addr = ~addr;
    host_wdata = ~val;
    repeat (3) @(negedge ref_clk);
  endtask : write_reg
endmodule : pmcr_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the modem control register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic task_active = 1'b0;
  logic status_irq_flag = 1'b0;
  logic status_read = 1'b0;
  logic symbol_event = 1'b0;
  logic symbol_is_spare = 1'b0;
  logic [1:0] rx_status_code = 2'h0;
  logic [1:0] host_addr, received_status_value;
  logic [7:0] host_wdata, data_wdata, last_data;
  logic host_cs_n, host_wr_n, data_write, symbol_tick, task_start, task_cancel, irq_line;
  logic binary_mode, transmit_mode, alt_checksum, alt_filter, correction_freeze;
  logic symbol_invert, analog_enable, osc_enable, tx_filter_bias, auto_sync_enable;
  logic eye_route, irq_set, status_symbol_ready, irq_pin_n_out, irq_pin_n_oe_n;
  logic [2:0] task_code, sync_tolerance, tx_status_level;
  int cyc = 0, last_tick = 0, tick_gap = 0, n_start = 0, n_cancel = 0, n_irq = 0, n_data = 0;
  int s_start, s_cancel, s_irq, s_data, exp_div, compares = 0, failures = 0;
  int divs[4] = '{512, 768, 1024, 1536};
  logic [2:0] lvl4[4] = '{3'h7, 3'h5, 3'h1, 3'h3};
  logic [2:0] lvl2[4] = '{3'h7, 3'h7, 3'h1, 3'h1};
  always #5 ref_clk = ~ref_clk;
  // Open-drain interrupt line with pull-up
  assign irq_line = irq_pin_n_oe_n ? 1'b1 : irq_pin_n_out;
  //////////////////////////////////////////////////////////////////////////////
  pmcr_regs pmcr_regs_inst (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata),
    .HOST_CS_N(host_cs_n), .HOST_WR_N(host_wr_n), .TASK_ACTIVE(task_active),
    .STATUS_IRQ_FLAG(status_irq_flag), .STATUS_READ(status_read),
    .SYMBOL_EVENT(symbol_event), .SYMBOL_IS_SPARE(symbol_is_spare),
    .RX_STATUS_CODE(rx_status_code), .DATA_WRITE(data_write), .DATA_WDATA(data_wdata),
    .SYMBOL_TICK(symbol_tick), .TASK_START(task_start), .TASK_CODE(task_code),
    .TASK_CANCEL(task_cancel), .BINARY_MODE(binary_mode), .TRANSMIT_MODE(transmit_mode),
    .ALT_CHECKSUM(alt_checksum), .ALT_FILTER(alt_filter), .SYNC_TOLERANCE(sync_tolerance),
    .CORRECTION_FREEZE(correction_freeze), .SYMBOL_INVERT(symbol_invert),
    .ANALOG_ENABLE(analog_enable), .OSC_ENABLE(osc_enable), .TX_FILTER_BIAS(tx_filter_bias),
    .AUTO_SYNC_ENABLE(auto_sync_enable), .EYE_ROUTE(eye_route),
    .TX_STATUS_LEVEL(tx_status_level), .IRQ_SET(irq_set),
    .STATUS_SYMBOL_READY(status_symbol_ready), .RECEIVED_STATUS_VALUE(received_status_value),
    .IRQ_PIN_N_OUT(irq_pin_n_out), .IRQ_PIN_N_OE_N(irq_pin_n_oe_n)
  );
  pmcr_host_model pmcr_host_model_inst (
    .ref_clk(ref_clk), .buffer_free_flag(1'b1), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n)
  );
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (symbol_tick) begin
      tick_gap <= cyc - last_tick;
      last_tick <= cyc;
    end
    if (task_start) n_start <= n_start + 1;
    if (task_cancel) n_cancel <= n_cancel + 1;
    if (irq_set) n_irq <= n_irq + 1;
    if (data_write) begin
      n_data <= n_data + 1;
      last_data <= data_wdata;
    end
  end
  always @(negedge ref_clk) begin
    if (cyc >= 40000) begin
      failures++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] expected);
    compares++;
    if (seen !== expected) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic snap();
    s_start = n_start;
    s_cancel = n_cancel;
    s_irq = n_irq;
    s_data = n_data;
  endtask : snap
  task automatic wctl(input logic [7:0] d);
    pmcr_host_model_inst.write_reg(pmcr_pkg::ADDR_CTRL, d);
  endtask : wctl
  task automatic wmod(input logic [7:0] d);
    pmcr_host_model_inst.write_reg(pmcr_pkg::ADDR_MODE, d);
  endtask : wmod
  task automatic wcmd(input logic [7:0] d);
    snap();
    pmcr_host_model_inst.write_reg(pmcr_pkg::ADDR_CMD, d);
  endtask : wcmd
  task automatic sym(input logic spare, input logic [1:0] code);
    snap();
    @(negedge ref_clk);
    symbol_event = 1'b1;
    symbol_is_spare = spare;
    rx_status_code = code;
    @(negedge ref_clk);
    symbol_event = 1'b0;
    symbol_is_spare = 1'b0;
    @(negedge ref_clk);
  endtask : sym
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    check({binary_mode, transmit_mode, alt_checksum, irq_pin_n_oe_n}, 12'h001);
    check({task_code, sync_tolerance, tx_status_level}, 12'h018);
    snap();
    wctl(8'h1b);
    check({alt_checksum, alt_filter}, 12'h003);
    check({correction_freeze, sync_tolerance}, 12'h00f);
    wctl(8'h3f);
    check({binary_mode, sync_tolerance}, 12'h00d);
    check({alt_checksum, alt_filter}, 12'h000);
    wctl(8'h1d);
    check(sync_tolerance, 12'h005);
    wctl(8'h00);
    check(12'(n_cancel - s_cancel), 12'h002);
    // Symbol period for every code, both protocols
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        exp_div = divs[c] * (b + 1);
        wctl({c[1:0], 3'h0, b[0], 2'h0});
        repeat (2 * exp_div + 20) @(negedge ref_clk);
        check(12'(tick_gap), 12'(exp_div));
      end
    end
    wctl(8'h00);
    snap();
    for (int m = 0; m < 2; m++) begin
      wctl({5'h0, m[0], 2'h0});
      for (int c = 0; c < 4; c++) begin
        wmod(8'h20 | 8'(c));
        check(tx_status_level, m ? lvl2[c] : lvl4[c]);
      end
    end
    wctl(8'h00);
    check({transmit_mode, 11'(n_cancel - s_cancel)}, 12'h803);
    check(tx_filter_bias, 12'h001);
    task_active = 1'b1;
    @(negedge ref_clk);
    check(tx_filter_bias, 12'h000);
    task_active = 1'b0;
    wcmd(8'hc1);
    check({auto_sync_enable, eye_route, 4'(n_start - s_start)}, 12'h001);
    wmod(8'h24);
    sym(1'b0, 2'h1);
    check({status_symbol_ready, 3'(n_irq - s_irq)}, 12'h009);
    check(received_status_value, 12'h000);
    wmod(8'h03);
    check(tx_status_level, 12'h000);
    wmod(8'h04);
    sym(1'b0, 2'h2);
    check({status_symbol_ready, 3'(n_irq - s_irq), received_status_value}, 12'h026);
    @(negedge ref_clk);
    status_read = 1'b1;
    @(negedge ref_clk);
    status_read = 1'b0;
    @(negedge ref_clk);
    check(status_symbol_ready, 12'h000);
    wctl(8'h04);
    sym(1'b1, 2'h3);
    check(12'(n_irq - s_irq), 12'h000);
    sym(1'b0, 2'h3);
    check(12'(n_irq - s_irq), 12'h001);
    wctl(8'h00);
    wmod(8'h00);
    sym(1'b0, 2'h1);
    check(12'(n_irq - s_irq), 12'h000);
    status_irq_flag = 1'b1;
    wmod(8'h80);
    check({irq_line, irq_pin_n_oe_n}, 12'h000);
    status_irq_flag = 1'b0;
    @(negedge ref_clk);
    check({irq_line, irq_pin_n_oe_n}, 12'h003);
    status_irq_flag = 1'b1;
    wmod(8'h00);
    check({irq_line, irq_pin_n_oe_n}, 12'h003);
    status_irq_flag = 1'b0;
    wmod(8'h48);
    check({symbol_invert, analog_enable, osc_enable}, 12'h005);
    wmod(8'h10);
    check({analog_enable, osc_enable}, 12'h000);
    wcmd(8'h03);
    check({task_code, 4'(n_start - s_start)}, 12'h010);
    wmod(8'h00);
    wcmd(8'hc2);
    check({auto_sync_enable, eye_route, task_code}, 12'h01a);
    for (int t = 1; t < 7; t++) begin
      wcmd(8'(t));
      check({task_code, 4'(n_start - s_start)}, 12'(t * 16 + 1));
    end
    wcmd(8'h07);
    check({4'(n_start - s_start), 4'(n_cancel - s_cancel)}, 12'h001);
    wcmd(8'h00);
    check(12'(n_start - s_start), 12'h000);
    snap();
    pmcr_host_model_inst.write_reg(pmcr_pkg::ADDR_DATA, 8'ha5);
    check({last_data, 4'(n_data - s_data)}, 12'ha51);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
